// *** logic/bfa_pkg.sv ***
package bfa_pkg;
  // One bit slot, sync pulse to sample point, in core_clk cycles.
  localparam int BIT_CYC = 8;
  localparam logic ACK_VAL = 1'b0;
  localparam logic [11:0] ADDR_ALL = 12'hFFF;
  localparam int DIR_BIT = 3;
  localparam logic [3:0] CT_STAT = 4'h0;
  localparam logic [3:0] CT_RD_LOCK = 4'h3;
  localparam logic [3:0] CT_LKA_LO = 4'h4;
  localparam logic [3:0] CT_LKA_HI = 4'h5;
  localparam logic [3:0] CT_STAT_UNLK = 4'h6;
  localparam logic [3:0] CT_RD = 4'h7;
  localparam logic [3:0] CT_WC_LOCK = 4'hA;
  localparam logic [3:0] CT_WD_LOCK = 4'hB;
  localparam logic [3:0] CT_WC = 4'hE;
  localparam logic [3:0] CT_WD = 4'hF;
  localparam int ST_TXNE = 0;
  localparam int ST_RXNE = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_TXEN = 4;
  localparam int ST_MODE = 6;
  localparam logic [1:0] MODE_TOP = 2'h2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_TXD = 8'h0C;
  localparam logic [7:0] REG_RXD = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_BCAST = 1;
  localparam int ADDR_DST = 16;
  localparam int CMD_LEN = 8;
  localparam int CMD_MAX = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_NAK = 2;
  localparam int STAT_TXV = 3;
  localparam int STAT_RXV = 4;
  localparam int STAT_FLD = 8;
  localparam int STAT_CNT = 16;

  typedef enum logic [2:0] {F_BC, F_MA, F_SA, F_CT, F_LN, F_DA} bfa_field_t;

  function automatic logic [3:0] bfa_width(input bfa_field_t f);
    case (f)
      F_BC: bfa_width = 4'h1;
      F_MA, F_SA: bfa_width = 4'hC;
      F_CT: bfa_width = 4'h4;
      default: bfa_width = 4'h8;
    endcase
  endfunction : bfa_width

  function automatic bfa_field_t bfa_next(input bfa_field_t f);
    case (f)
      F_BC: bfa_next = F_MA;
      F_MA: bfa_next = F_SA;
      F_SA: bfa_next = F_CT;
      F_CT: bfa_next = F_LN;
      default: bfa_next = F_DA;
    endcase
  endfunction : bfa_next

  // A length byte of zero stands for 256.
  function automatic logic [8:0] bfa_len(input logic [7:0] n);
    bfa_len = {n == 8'h00, n};
  endfunction : bfa_len

  function automatic logic bfa_defined(input logic [3:0] c);
    bfa_defined = c inside {CT_STAT, CT_RD_LOCK, CT_LKA_LO, CT_LKA_HI, CT_STAT_UNLK,
                            CT_RD, CT_WC_LOCK, CT_WD_LOCK, CT_WC, CT_WD};
  endfunction : bfa_defined

  function automatic logic bfa_locks(input logic [3:0] c);
    bfa_locks = c inside {CT_RD_LOCK, CT_WC_LOCK, CT_WD_LOCK};
  endfunction : bfa_locks
endpackage : bfa_pkg

// *** logic/bfa_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bfa_if;
  logic sync;
  logic frame;
  logic m_out;
  logic m_oe;
  logic s_out;
  logic s_oe;
  logic line;
  // Zero is dominant: a released line reads one.
  assign line = ~((m_oe & ~m_out) | (s_oe & ~s_out));
  modport ctl (output sync, output frame, output m_out, output m_oe, input line);
  modport unit (input sync, input frame, input line, output s_out, output s_oe);
endinterface : bfa_if
`default_nettype wire

// *** logic/bfa_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module bfa_unit
  import bfa_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  bfa_if.unit lnk,
  input wire logic [11:0] my_addr,
  input wire logic slave_tx_request_flag,
  input wire logic slave_rx_enable_flag,
  input wire logic tx_enable_cfg,
  input wire logic tx_nonempty,
  input wire logic [7:0] tx_len,
  input wire logic [7:0] tx_data,
  input wire logic rx_nonempty,
  input wire logic rx_full,
  input wire logic timing_err,
  output logic tx_pop,
  output logic rx_push,
  output logic [7:0] rx_data,
  output logic locked,
  output logic [11:0] lock_addr,
  output logic [7:0] slave_status_byte
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 200) begin : g_chk
    $error("BIT_CYCLES must lie in 4..200");
  end

  typedef enum logic [1:0] {SL_IDLE, SL_RUN, SL_STOP} bfa_sl_state_t;

  bfa_sl_state_t st;
  bfa_field_t fld;
  logic [3:0] bi;
  logic [7:0] scnt;
  logic slot_on;
  logic [11:0] sh;
  logic [11:0] master_id;
  logic par;
  logic hdr_bad;
  logic bcast;
  logic wr;
  logic nak;
  logic terr;
  logic len_ok;
  logic [3:0] code;
  logic [8:0] len_total;
  logic [8:0] done;
  logic [8:0] att;

  logic [3:0] w;
  logic is_dat;
  logic is_par;
  logic is_ack;
  logic b;
  logic sample;
  logic pe;
  logic tx_ready;
  logic rx_busy;
  logic ok;
  logic frame_end;
  logic addressed;
  logic ctl_bad;
  logic rd_data;
  logic [3:0] c_in;
  logic [8:0] rd_len;
  logic [7:0] rd_byte;
  logic [7:0] out_byte;
  logic sends;
  logic acks;
  logic da_ack;
  logic [7:0] next_status;

  assign w = bfa_width(fld);
  assign is_dat = bi < w;
  assign is_par = (bi == w) && (fld != F_BC);
  assign is_ack = bi == w + 4'h1;
  assign b = lnk.line;
  assign sample = ce && slot_on && scnt == 8'(BIT_CYCLES - 1);
  assign pe = par ^ b;
  assign tx_ready = slave_tx_request_flag & tx_nonempty;
  assign rx_busy = ~slave_rx_enable_flag | rx_nonempty;
  // Broadcast acks are ignored; our own reject still stops us before the data field.
  assign ok = ~nak & (bcast | b == ACK_VAL);
  assign frame_end = ce & ~lnk.frame & (st != SL_IDLE);
  assign addressed = bcast ? (sh == ADDR_ALL || sh[11:8] == my_addr[11:8]) : sh == my_addr;
  assign c_in = sh[3:0];
  assign rd_data = code == CT_RD_LOCK || code == CT_RD;

  // Control field checks on the freshly shifted code.
  always_comb begin
    ctl_bad = ~bfa_defined(c_in);
    if (bcast && !c_in[DIR_BIT]) begin
      ctl_bad = 1'b1;
    end
    if (c_in[DIR_BIT] && rx_busy) begin
      ctl_bad = 1'b1;
    end
    if ((c_in == CT_RD_LOCK || c_in == CT_RD) && !tx_ready) begin
      ctl_bad = 1'b1;
    end
    if (locked && master_id != lock_addr && !(c_in inside {CT_STAT, CT_LKA_LO, CT_LKA_HI})) begin
      ctl_bad = 1'b1;
    end
    if (c_in == CT_LKA_LO && !locked) begin
      ctl_bad = 1'b1;
    end
  end

  // Read side source per code.
  always_comb begin
    rd_len = (code == CT_RD_LOCK || code == CT_RD) ? bfa_len(tx_len) : bfa_len(8'h01);
    case (code)
      CT_STAT, CT_STAT_UNLK: rd_byte = slave_status_byte;
      CT_LKA_LO: rd_byte = lock_addr[7:0];
      CT_LKA_HI: rd_byte = {4'h0, lock_addr[11:8]};
      CT_RD_LOCK, CT_RD: rd_byte = tx_data;
      default: rd_byte = 8'h00;
    endcase
    out_byte = (fld == F_LN) ? rd_len[7:0] : rd_byte;
  end

  assign sends = (fld == F_LN || fld == F_DA) && !wr;
  assign acks = (fld == F_SA || fld == F_CT || wr) && !bcast && !nak;
  assign da_ack = (st == SL_RUN) && sample && is_ack && fld == F_DA && ok;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scnt <= 8'h00;
      slot_on <= 1'b0;
    end else if (ce) begin
      if (lnk.sync) begin
        scnt <= 8'h01;
        slot_on <= 1'b1;
      end else if (sample) begin
        slot_on <= 1'b0;
      end else if (slot_on) begin
        scnt <= scnt + 8'h01;
      end
    end
  end

  // A timing error stays pending until the next ack slot or the end of the frame; a new error wins.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      terr <= 1'b0;
    end else if (ce) begin
      terr <= timing_err | (terr & lnk.frame & ~(sample & is_ack));
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= SL_IDLE;
      fld <= F_BC;
      bi <= 4'h0;
      sh <= 12'h000;
      par <= 1'b0;
      hdr_bad <= 1'b0;
      bcast <= 1'b0;
      wr <= 1'b0;
      nak <= 1'b0;
      len_ok <= 1'b0;
      code <= CT_STAT;
      master_id <= 12'h000;
      len_total <= 9'h000;
      done <= 9'h000;
      att <= 9'h000;
    end else if (ce) begin
      if (!lnk.frame) begin
        st <= SL_IDLE;
      end else if (st == SL_IDLE) begin
        st <= SL_RUN;
        fld <= F_BC;
        bi <= 4'h0;
        par <= 1'b0;
        nak <= 1'b0;
        hdr_bad <= 1'b0;
        len_ok <= 1'b0;
        done <= 9'h000;
        att <= 9'h000;
      end else if (st == SL_RUN && sample) begin
        bi <= bi + 4'h1;
        if (is_dat) begin
          sh <= {sh[10:0], b};
          par <= par ^ b;
          if (fld == F_BC) begin
            bcast <= ~b;
            par <= 1'b0;
            fld <= F_MA;
            bi <= 4'h0;
          end
        end else if (is_par) begin
          par <= 1'b0;
          nak <= 1'b0;
          case (fld)
            F_MA: begin
              master_id <= sh;
              hdr_bad <= pe;
              fld <= F_SA;
              bi <= 4'h0;
            end
            F_SA: begin
              if (!addressed) begin
                st <= SL_STOP;
              end
              nak <= pe | hdr_bad | terr;
            end
            F_CT: begin
              code <= c_in;
              wr <= c_in[DIR_BIT];
              nak <= pe | terr | ctl_bad;
            end
            F_LN: begin
              if (wr) begin
                nak <= pe | terr;
                len_total <= bfa_len(sh[7:0]);
              end
            end
            F_DA: begin
              if (wr) begin
                nak <= pe | terr | rx_full | ~slave_rx_enable_flag;
              end
            end
            default: ;
          endcase
        end else if (is_ack) begin
          bi <= 4'h0;
          case (fld)
            F_SA, F_CT: begin
              if (ok) begin
                fld <= bfa_next(fld);
                if (fld == F_CT && !wr) begin
                  len_total <= rd_len;
                end
              end else begin
                st <= SL_STOP;
              end
            end
            F_LN: begin
              if (ok) begin
                fld <= F_DA;
                len_ok <= ~bcast;
              end else begin
                st <= SL_STOP;
              end
            end
            F_DA: begin
              // Rejected bytes are resent by the sender until the limit.
              att <= att + 9'h001;
              if (ok) begin
                done <= done + 9'h001;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lnk.s_oe <= 1'b0;
      lnk.s_out <= 1'b1;
    end else if (ce) begin
      if (!lnk.frame || st != SL_RUN) begin
        lnk.s_oe <= 1'b0;
        lnk.s_out <= 1'b1;
      end else if (lnk.sync) begin
        lnk.s_oe <= 1'b0;
        lnk.s_out <= 1'b1;
        if (sends && is_dat) begin
          lnk.s_oe <= 1'b1;
          lnk.s_out <= out_byte[3'(4'h7 - bi)];
        end else if (sends && is_par) begin
          lnk.s_oe <= 1'b1;
          lnk.s_out <= ^out_byte;
        end else if (is_ack && acks) begin
          lnk.s_oe <= 1'b1;
          lnk.s_out <= ACK_VAL;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_push <= 1'b0;
      rx_data <= 8'h00;
      tx_pop <= 1'b0;
    end else if (ce) begin
      rx_push <= da_ack & wr;
      tx_pop <= da_ack & ~wr & rd_data;
      if (da_ack && wr) begin
        rx_data <= sh[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      locked <= 1'b0;
      lock_addr <= 12'h000;
    end else if (frame_end && len_ok) begin
      if (bfa_locks(code) && done != len_total) begin
        locked <= 1'b1;
        lock_addr <= master_id;
      end else if ((bfa_locks(code) || code == CT_STAT_UNLK) && done == len_total) begin
        locked <= 1'b0;
      end
    end
  end

  always_comb begin
    next_status = 8'h00;
    next_status[ST_TXNE] = tx_ready;
    next_status[ST_RXNE] = rx_busy;
    next_status[ST_LOCK] = locked;
    next_status[ST_TXEN] = tx_enable_cfg;
    next_status[ST_MODE +: 2] = MODE_TOP;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slave_status_byte <= 8'h00;
    end else if (ce) begin
      slave_status_byte <= next_status;
    end
  end
endmodule : bfa_unit
`default_nettype wire

// *** logic/bfa_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module bfa_master
  import bfa_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  bfa_if.ctl lnk
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 200) begin : g_chk
    $error("BIT_CYCLES must lie in 4..200");
  end

  logic bcast;
  logic [11:0] own_addr;
  logic [11:0] dst_addr;
  logic [3:0] code;
  logic [7:0] len_cfg;
  logic [7:0] max_cfg;
  logic [7:0] txd;
  logic txd_v;
  logic [7:0] rxd;
  logic rxd_v;
  logic busy;
  logic complete;
  logic naked;
  logic [2:0] nak_fld;
  logic [8:0] done;
  logic [8:0] att;
  logic [8:0] len_total;
  logic [7:0] cnt;
  bfa_field_t fld;
  logic [3:0] bi;
  logic [11:0] sh;
  logic par;
  logic acc_ok;

  logic take;
  logic wr;
  logic start;
  logic stall;
  logic go;
  logic samp;
  logic [3:0] w;
  logic is_dat;
  logic is_par;
  logic is_ack;
  logic b;
  logic ok;
  logic da_ok;
  logic last;
  logic [11:0] mval;
  logic [31:0] rd_mux;

  assign take = psel & penable & pready;
  assign wr = code[DIR_BIT];
  assign start = take & pwrite & paddr == REG_CTRL & pwdata[CTRL_START] & ~busy;
  // On a write, no data-field sync goes out until software has supplied the next byte.
  assign stall = fld == F_DA && wr && bi == 4'h0 && !txd_v;
  assign go = ce && lnk.frame && cnt == 8'h00 && !stall;
  assign samp = ce && cnt == 8'(BIT_CYCLES);
  assign w = bfa_width(fld);
  assign is_dat = bi < w;
  assign is_par = (bi == w) && (fld != F_BC);
  assign is_ack = bi == w + 4'h1;
  assign b = lnk.line;
  assign ok = bcast | b == ACK_VAL;
  assign da_ok = samp && is_ack && fld == F_DA && ok;
  assign last = (da_ok && done + 9'h001 == len_total) || att + 9'h001 == {1'b0, max_cfg};

  always_comb begin
    case (fld)
      F_BC: mval = {11'h000, ~bcast};
      F_MA: mval = own_addr;
      F_SA: mval = dst_addr;
      F_CT: mval = {8'h00, code};
      F_LN: mval = {4'h0, len_cfg};
      default: mval = {4'h0, txd};
    endcase
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_mux[CTRL_BCAST] = bcast;
      REG_ADDR: rd_mux = {4'h0, dst_addr, 4'h0, own_addr};
      REG_CMD: rd_mux = {8'h00, max_cfg, len_cfg, 4'h0, code};
      REG_TXD: rd_mux = {24'h000000, txd};
      REG_RXD: rd_mux = {24'h000000, rxd};
      REG_STAT: begin
        rd_mux[STAT_BUSY] = busy;
        rd_mux[STAT_DONE] = complete;
        rd_mux[STAT_NAK] = naked;
        rd_mux[STAT_TXV] = txd_v;
        rd_mux[STAT_RXV] = rxd_v;
        rd_mux[STAT_FLD +: 3] = nak_fld;
        rd_mux[STAT_CNT +: 9] = done;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(paddr inside {REG_CTRL, REG_ADDR,
                 REG_CMD, REG_TXD, REG_RXD, REG_STAT});
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bcast <= 1'b0;
      own_addr <= 12'h000;
      dst_addr <= 12'h000;
      code <= CT_STAT;
      len_cfg <= 8'h01;
      max_cfg <= 8'h00;
    end else if (ce && take && pwrite && !busy) begin
      case (paddr)
        REG_CTRL: bcast <= pwdata[CTRL_BCAST];
        REG_ADDR: begin
          own_addr <= pwdata[11:0];
          dst_addr <= pwdata[ADDR_DST +: 12];
        end
        REG_CMD: begin
          code <= pwdata[3:0];
          len_cfg <= pwdata[CMD_LEN +: 8];
          max_cfg <= pwdata[CMD_MAX +: 8];
        end
        default: ;
      endcase
    end
  end

  // Data buffers: a new byte from either side wins over a same-cycle clear.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txd <= 8'h00;
      txd_v <= 1'b0;
      rxd <= 8'h00;
      rxd_v <= 1'b0;
    end else if (ce) begin
      if (take && pwrite && paddr == REG_TXD) begin
        txd <= pwdata[7:0];
        txd_v <= 1'b1;
      end else if (da_ok && wr) begin
        txd_v <= 1'b0;
      end
      if (da_ok && !wr) begin
        rxd <= sh[7:0];
        rxd_v <= 1'b1;
      end else if (take && !pwrite && paddr == REG_RXD) begin
        rxd_v <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lnk.frame <= 1'b0;
      busy <= 1'b0;
      complete <= 1'b0;
      naked <= 1'b0;
      nak_fld <= 3'h0;
      cnt <= 8'h00;
      fld <= F_BC;
      bi <= 4'h0;
      sh <= 12'h000;
      par <= 1'b0;
      acc_ok <= 1'b0;
      done <= 9'h000;
      att <= 9'h000;
      len_total <= 9'h000;
    end else if (ce && start) begin
      lnk.frame <= 1'b1;
      busy <= 1'b1;
      complete <= 1'b0;
      naked <= 1'b0;
      cnt <= 8'h00;
      fld <= F_BC;
      bi <= 4'h0;
      par <= 1'b0;
      done <= 9'h000;
      att <= 9'h000;
    end else if (ce && lnk.frame) begin
      if (go) begin
        cnt <= 8'h01;
      end else if (samp) begin
        cnt <= 8'h00;
        bi <= bi + 4'h1;
        if (is_dat) begin
          sh <= {sh[10:0], b};
          par <= par ^ b;
          if (fld == F_BC) begin
            par <= 1'b0;
            fld <= F_MA;
            bi <= 4'h0;
          end
        end else if (is_par) begin
          par <= 1'b0;
          acc_ok <= ~(par ^ b) & (fld == F_LN | ~rxd_v);
          if (fld == F_MA) begin
            fld <= F_SA;
            bi <= 4'h0;
          end
        end else if (is_ack) begin
          bi <= 4'h0;
          if (fld == F_DA) begin
            att <= att + 9'h001;
            if (ok) begin
              done <= done + 9'h001;
            end
            if (last) begin
              lnk.frame <= 1'b0;
              busy <= 1'b0;
              complete <= da_ok;
            end
          end else if (ok && !(fld == F_CT && bcast && !wr)) begin
            fld <= bfa_next(fld);
            if (fld == F_LN) begin
              len_total <= bfa_len(wr ? len_cfg : sh[7:0]);
            end
          end else begin
            lnk.frame <= 1'b0;
            busy <= 1'b0;
            naked <= 1'b1;
            nak_fld <= fld;
          end
        end
      end else if (cnt != 8'h00) begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lnk.sync <= 1'b0;
      lnk.m_oe <= 1'b0;
      lnk.m_out <= 1'b1;
    end else if (ce) begin
      lnk.sync <= go;
      if (go) begin
        lnk.m_oe <= 1'b0;
        lnk.m_out <= 1'b1;
        if ((fld <= F_CT || wr) && is_dat) begin
          lnk.m_oe <= 1'b1;
          lnk.m_out <= mval[4'(w - 4'h1 - bi)];
        end else if ((fld <= F_CT || wr) && is_par) begin
          lnk.m_oe <= 1'b1;
          lnk.m_out <= ^mval;
        end else if (is_ack && !wr && fld >= F_LN && acc_ok && !bcast) begin
          lnk.m_oe <= 1'b1;
          lnk.m_out <= ACK_VAL;
        end
      end else if (!lnk.frame) begin
        lnk.m_oe <= 1'b0;
        lnk.m_out <= 1'b1;
      end
    end
  end
endmodule : bfa_master
`default_nettype wire

// *** verif/bfa_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module bfa_chk_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sync,
  input wire logic frame,
  input wire logic m_out,
  input wire logic m_oe,
  input wire logic s_out,
  input wire logic s_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // The count of eight quiet cycles assumes the default slot length.
  chk_sync_spacing: assert property (sync |=> !sync [*8])
    else $error("sync pulses too close");
  chk_sync_in_frame: assert property (sync |-> frame)
    else $error("sync outside frame");
  chk_frame_first_sync: assert property ($rose(frame) |-> ##[0:40] sync)
    else $error("no sync after frame start");
  chk_master_hold: assert property (frame && $past(frame) && !sync
    |-> $stable(m_out) && $stable(m_oe))
    else $error("master changed mid slot");
  chk_unit_hold: assert property (frame && $past(frame) && !$past(sync)
    |-> $stable(s_out) && $stable(s_oe))
    else $error("unit changed mid slot");
  chk_master_idle: assert property (m_oe |-> frame || $past(frame))
    else $error("master drives outside frame");
  chk_unit_idle: assert property (s_oe |-> frame || $past(frame))
    else $error("unit drives outside frame");
  chk_frame_end: assert property ($fell(frame) |-> !sync && !$past(sync))
    else $error("frame ended inside slot start");
endmodule : bfa_chk_sva
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bfa_pkg::*;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr, txd, rxd, cap, ssb;
  logic [31:0] pwdata, prdata, q, st;
  logic txr, rxe, txn, rxn, rxf, pop, push, lk;
  logic [11:0] lka;
  logic [3:0] bad [7] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hC, 4'hD, 4'h4};
  int errors, n_tests;
  int npop = 0;
  bfa_if bfa_if_inst ();
  bfa_master bfa_master_inst (.core_clk, .nrst, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lnk(bfa_if_inst.ctl));
  bfa_unit bfa_unit_inst (.core_clk, .nrst, .ce(1'b1), .lnk(bfa_if_inst.unit),
    .my_addr(12'h456), .slave_tx_request_flag(txr), .slave_rx_enable_flag(rxe),
    .tx_enable_cfg(txr), .tx_nonempty(txn), .tx_len(8'h01), .tx_data(txd),
    .rx_nonempty(rxn), .rx_full(rxf), .timing_err(1'b0), .tx_pop(pop),
    .rx_push(push), .rx_data(rxd), .locked(lk), .lock_addr(lka), .slave_status_byte(ssb));
  bfa_chk_sva bfa_chk_sva_inst (.core_clk, .nrst, .sync(bfa_if_inst.sync),
    .frame(bfa_if_inst.frame), .m_out(bfa_if_inst.m_out), .m_oe(bfa_if_inst.m_oe),
    .s_out(bfa_if_inst.s_out), .s_oe(bfa_if_inst.s_oe));
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (push === 1'b1) cap <= rxd;
  always @(posedge core_clk) if (pop === 1'b1) npop <= npop + 1;
  task print_verdict;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      errors++;
      print_verdict;
    end
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    // One idle cycle keeps each strobe to a single assignment per time step.
    @(posedge core_clk);
  endtask : apb
  task run(input logic [3:0] c, input logic [7:0] n, input logic [7:0] lim);
    int i;
    apb(1, REG_CMD, {8'h00, lim, n, 4'h0, c});
    apb(1, REG_CTRL, 32'h1);
    i = 0;
    do begin
      apb(0, REG_STAT, 0);
      i++;
    end while (q[STAT_BUSY] !== 1'b0 && i < 400);
    if (q[STAT_BUSY] !== 1'b0) begin
      errors++;
      print_verdict;
    end
    st = q;
  endtask : run
  initial begin
    {psel, penable, pwrite, paddr, pwdata, nrst, rxn, rxf, cap} = '0;
    {txr, rxe, txn} = 3'h7;
    txd = 8'hA5;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    apb(1, REG_ADDR, 32'h0456_0123);
    apb(0, 8'h40, 0);
    cmp(se, 1);
    run(CT_STAT, 1, 0);
    cmp(st[2:1], 2'b01);
    // The status byte is left unread so the next frame meets a full buffer.
    run(CT_STAT, 1, 2);
    cmp(st[24:16], 0);
    apb(0, REG_RXD, 0);
    cmp(q[7:0], 8'h91);
    cmp(ssb, 8'h91);
    for (int k = 0; k < 7; k++) begin
      run(bad[k], 1, 1);
      cmp({st[STAT_NAK], st[10:8]}, 4'hB);
    end
    rxn <= 1;
    run(CT_WD, 1, 1);
    cmp(st[10:8], 3);
    rxn <= 0;
    txn <= 0;
    run(CT_RD, 1, 1);
    cmp(st[10:8], 3);
    txn <= 1;
    apb(1, REG_TXD, 32'h5A);
    // A full receive buffer rejects every attempt until the limit runs out.
    rxf <= 1;
    run(CT_WD, 1, 2);
    cmp({st[STAT_DONE], st[24:16]}, 0);
    rxf <= 0;
    run(CT_WD, 1, 0);
    cmp({st[2:1], cap}, {2'b01, 8'h5A});
    run(CT_RD, 1, 0);
    apb(0, REG_RXD, 0);
    cmp(q[7:0], 8'hA5);
    cmp(npop, 1);
    apb(1, REG_ADDR, 32'h0457_0123);
    run(CT_STAT, 1, 0);
    cmp({st[STAT_NAK], st[10:8]}, 4'hA);
    apb(1, REG_ADDR, 32'h0456_0123);
    apb(1, REG_TXD, 32'h11);
    run(CT_WD_LOCK, 2, 1);
    cmp({lk, lka, ssb[ST_LOCK]}, {1'b1, 12'h123, 1'b1});
    apb(1, REG_ADDR, 32'h0456_0321);
    run(CT_RD, 1, 1);
    cmp(st[10:8], 3);
    run(CT_LKA_LO, 1, 0);
    apb(0, REG_RXD, 0);
    cmp(q[7:0], 8'h23);
    apb(1, REG_ADDR, 32'h0456_0123);
    run(CT_STAT_UNLK, 1, 0);
    cmp(lk, 0);
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
